// file: design/ptu_pkg.sv
// constants and types shared by the pulse timer unit channel
// =============================================================
// Functional notes
// - flag clears on write 0 after read 1
// - match clear gives period of N+1 clocks
// - clear during write state two wins
// - counter write beats simultaneous increment
// - compare register write suppresses match
// - buffered match transfers the pre-write buffer value
// - capture in state one is read back
// - capture beats compare register write
// - capture transfer beats buffer write
// - clear with wrap sets no wrap flag
// - counter write with wrap sets no wrap flag
// - unit stopped until module stop cancelled
// - flag and enable both high request interrupt
// - one match per counter input clock
package ptu_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned EVT_W = 3;
  localparam int unsigned ADDR_W = 3;
  // register selects on the access port
  localparam logic [ADDR_W-1:0] SEL_COUNTER = 3'h0;
  localparam logic [ADDR_W-1:0] SEL_CAPCMP = 3'h1;
  localparam logic [ADDR_W-1:0] SEL_BUFFER = 3'h2;
  localparam logic [ADDR_W-1:0] SEL_FLAGS = 3'h3;
  localparam logic [ADDR_W-1:0] SEL_ENABLE = 3'h4;
  // event flag / enable bit positions
  localparam int unsigned EVT_MATCH = 0;
  localparam int unsigned EVT_OVF = 1;
  localparam int unsigned EVT_UDF = 2;
  // reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CAPCMP_RESET = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
  // internal prescaler divide-by codes 1,4,16,64 as counter masks
  localparam logic [5:0] PRE_MASK_1 = 6'h00;
  localparam logic [5:0] PRE_MASK_4 = 6'h03;
  localparam logic [5:0] PRE_MASK_16 = 6'h0f;
  localparam logic [5:0] PRE_MASK_64 = 6'h3f;
  // external edge select
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_T1 = 3'b010,
    BUS_T2 = 3'b100
  } ptu_bus_t;
endpackage : ptu_pkg

// file: design/ptu_count_src.sv
// count-clock source: internal prescaler, external edges, phase counting
`timescale 1ns/10ps
module ptu_count_src
  import ptu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  input wire logic ext_sel_in,
  input wire logic phase_mode_in,
  input wire logic [1:0] pre_sel_in,
  input wire logic [1:0] edge_sel_in,
  // external clocks
  input wire logic ext_clock_a_in,
  input wire logic ext_clock_b_in,
  // count strobe
  output logic tick_out,
  output logic up_out
);
  logic [5:0] pre_reg, pre_next;
  logic a_reg, a_next, b_reg, b_next;
  logic [5:0] mask;

  always_comb begin
    case (pre_sel_in)
      2'h0: mask = PRE_MASK_1;
      2'h1: mask = PRE_MASK_4;
      2'h2: mask = PRE_MASK_16;
      default: mask = PRE_MASK_64;
    endcase
    pre_next = run_in ? pre_reg + 6'h01 : pre_reg;
    a_next = ext_clock_a_in;
    b_next = ext_clock_b_in;
    tick_out = 1'b0;
    up_out = 1'b1;
    if (!run_in) begin
      tick_out = 1'b0;
    end else if (phase_mode_in) begin
      // quadrature: exactly one input moved; direction from the other input
      tick_out = (a_reg ^ ext_clock_a_in) ^ (b_reg ^ ext_clock_b_in);
      up_out = ext_clock_a_in ^ b_reg;
    end else if (ext_sel_in) begin
      case (edge_sel_in)
        EDGE_RISE: tick_out = ext_clock_a_in & ~a_reg;
        EDGE_FALL: tick_out = ~ext_clock_a_in & a_reg;
        default: tick_out = ext_clock_a_in ^ a_reg;
      endcase
    end else begin
      tick_out = (pre_reg & mask) == mask;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pre_reg <= 6'h00;
      a_reg <= 1'b0;
      b_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      a_reg <= a_next;
      b_reg <= b_next;
    end
  end
endmodule : ptu_count_src

// file: design/ptu_flags.sv
// sticky event flags with read-one-then-write-zero clearing
`timescale 1ns/10ps
module ptu_flags
  import ptu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // hardware events and software access
  input wire logic [EVT_W-1:0] set_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [EVT_W-1:0] wdata_in,
  // flag state
  output logic [EVT_W-1:0] flag_out
);
  logic [EVT_W-1:0] flag_reg, flag_next;
  logic [EVT_W-1:0] armed_reg, armed_next;

  for (genvar i = 0; i < EVT_W; i++) begin : g_flag
    always_comb begin
      flag_next[i] = flag_reg[i];
      armed_next[i] = armed_reg[i];
      if (rd_in && flag_reg[i]) begin
        armed_next[i] = 1'b1;
      end
      if (wr_in && !wdata_in[i] && armed_reg[i]) begin
        flag_next[i] = 1'b0;
        armed_next[i] = 1'b0;
      end
      // a set in the clearing cycle must not be lost
      if (set_in[i]) begin
        flag_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flag_reg <= EVT_RESET;
      armed_reg <= EVT_RESET;
    end else begin
      flag_reg <= flag_next;
      armed_reg <= armed_next;
    end
  end

  assign flag_out = flag_reg;
endmodule : ptu_flags

// file: design/ptu_core.sv
// one timer channel: counter, compare/capture, buffer, flags, cpu access
`timescale 1ns/10ps
module ptu_core
  import ptu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // module stop and mode control
  input wire logic run_in,
  input wire logic ext_sel_in,
  input wire logic phase_mode_in,
  input wire logic [1:0] pre_sel_in,
  input wire logic [1:0] edge_sel_in,
  input wire logic capture_mode_in,
  input wire logic buffered_in,
  input wire logic clr_on_match_in,
  input wire logic clr_on_capture_in,
  input wire logic cmp_out_en_in,
  // external clocks and capture strobe
  input wire logic ext_clock_a_in,
  input wire logic ext_clock_b_in,
  input wire logic capture_in,
  // cpu access port
  input wire logic cpu_req_in,
  input wire logic cpu_wr_in,
  input wire logic [ADDR_W-1:0] cpu_addr_in,
  input wire logic [CNT_W-1:0] cpu_wdata_in,
  output logic cpu_ack_out,
  output logic [CNT_W-1:0] cpu_rdata_out,
  // status and pins
  output logic [CNT_W-1:0] count_out,
  output logic [EVT_W-1:0] flags_out,
  output logic irq_out,
  output logic cmp_pin_out,
  output logic cmp_pin_oe_out
);
  // =============================================================
  // access sequencer
  ptu_bus_t bus_reg, bus_next;
  logic wr_reg, wr_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [CNT_W-1:0] wdata_reg, wdata_next;
  logic [CNT_W-1:0] rdata_reg, rdata_next;
  logic in_t1, in_t2;

  assign in_t1 = bus_reg == BUS_T1;
  assign in_t2 = bus_reg == BUS_T2;

  always_comb begin
    bus_next = bus_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    case (bus_reg)
      BUS_IDLE: begin
        // requests while stopped are ignored
        if (cpu_req_in && run_in) begin
          bus_next = BUS_T1;
          wr_next = cpu_wr_in;
          addr_next = cpu_addr_in;
          wdata_next = cpu_wdata_in;
        end
      end
      BUS_T1: bus_next = BUS_T2;
      BUS_T2: bus_next = BUS_IDLE;
      default: bus_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus_reg <= BUS_IDLE;
      wr_reg <= 1'b0;
      addr_reg <= SEL_COUNTER;
      wdata_reg <= CNT_RESET;
    end else begin
      bus_reg <= bus_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // write strobes act only at the end of the second state
  logic cnt_wr, cc_wr, buf_wr, flag_wr, en_wr, flag_rd;
  assign cnt_wr = in_t2 && wr_reg && addr_reg == SEL_COUNTER;
  assign cc_wr = in_t2 && wr_reg && addr_reg == SEL_CAPCMP;
  assign buf_wr = in_t2 && wr_reg && addr_reg == SEL_BUFFER;
  assign flag_wr = in_t2 && wr_reg && addr_reg == SEL_FLAGS;
  assign en_wr = in_t2 && wr_reg && addr_reg == SEL_ENABLE;
  assign flag_rd = in_t1 && !wr_reg && addr_reg == SEL_FLAGS;

  // =============================================================
  // count source
  logic tick, up;

  ptu_count_src u_src (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(run_in),
    .ext_sel_in(ext_sel_in),
    .phase_mode_in(phase_mode_in),
    .pre_sel_in(pre_sel_in),
    .edge_sel_in(edge_sel_in),
    .ext_clock_a_in(ext_clock_a_in),
    .ext_clock_b_in(ext_clock_b_in),
    .tick_out(tick),
    .up_out(up)
  );

  // =============================================================
  // counter, compare/capture and buffer
  logic [CNT_W-1:0] cycle_counter_reg, cycle_counter_next;
  logic [CNT_W-1:0] capture_compare_reg, capture_compare_next;
  logic [CNT_W-1:0] buffer_reg, buffer_next;
  logic [EVT_W-1:0] event_enable_reg, event_enable_next;
  logic cmp_pin_reg, cmp_pin_next;
  logic cap_evt, cmp_match, clr, ovf, udf;
  logic [EVT_W-1:0] evt_set;

  assign cap_evt = run_in && capture_mode_in && capture_in;
  // match only on an input clock, so at most one per count; write in second state masks it
  assign cmp_match = tick && !capture_mode_in && !cc_wr
    && cycle_counter_reg == capture_compare_reg;
  assign clr = (clr_on_match_in && cmp_match) || (clr_on_capture_in && cap_evt);
  assign ovf = tick && up && cycle_counter_reg == CNT_MAX;
  assign udf = tick && !up && cycle_counter_reg == CNT_RESET;

  always_comb begin
    evt_set = EVT_RESET;
    evt_set[EVT_MATCH] = cmp_match || cap_evt;
    evt_set[EVT_OVF] = ovf && !clr && !cnt_wr;
    evt_set[EVT_UDF] = udf && !clr && !cnt_wr;
  end

  always_comb begin
    cycle_counter_next = cycle_counter_reg;
    if (clr) begin
      // clearing in the last matching state gives a period of set value plus one
      cycle_counter_next = CNT_RESET;
    end else if (cnt_wr) begin
      cycle_counter_next = wdata_reg;
    end else if (tick) begin
      cycle_counter_next = up ? cycle_counter_reg + 16'h0001 : cycle_counter_reg - 16'h0001;
    end
  end

  always_comb begin
    capture_compare_next = capture_compare_reg;
    buffer_next = buffer_reg;
    if (cap_evt) begin
      capture_compare_next = cycle_counter_reg;
      if (buffered_in) begin
        buffer_next = capture_compare_reg;
      end else if (buf_wr) begin
        buffer_next = wdata_reg;
      end
    end else begin
      if (cc_wr) begin
        capture_compare_next = wdata_reg;
      end else if (buffered_in && cmp_match) begin
        capture_compare_next = buffer_reg;
      end
      if (buf_wr) begin
        buffer_next = wdata_reg;
      end
    end
  end

  always_comb begin
    event_enable_next = en_wr ? wdata_reg[EVT_W-1:0] : event_enable_reg;
    cmp_pin_next = cmp_match ? ~cmp_pin_reg : cmp_pin_reg;
    rdata_next = rdata_reg;
    if (in_t1 && !wr_reg) begin
      if (addr_reg == SEL_COUNTER) begin
        rdata_next = cycle_counter_reg;
      end else if (addr_reg == SEL_CAPCMP) begin
        // a capture in the first state is forwarded to the reader
        rdata_next = cap_evt ? cycle_counter_reg : capture_compare_reg;
      end else if (addr_reg == SEL_BUFFER) begin
        rdata_next = buffer_reg;
      end else if (addr_reg == SEL_FLAGS) begin
        rdata_next = {13'h0000, flags_out};
      end else if (addr_reg == SEL_ENABLE) begin
        rdata_next = {13'h0000, event_enable_reg};
      end else begin
        rdata_next = CNT_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cycle_counter_reg <= CNT_RESET;
      capture_compare_reg <= CAPCMP_RESET;
      buffer_reg <= CAPCMP_RESET;
      event_enable_reg <= EVT_RESET;
      cmp_pin_reg <= 1'b0;
      rdata_reg <= CNT_RESET;
    end else begin
      cycle_counter_reg <= cycle_counter_next;
      capture_compare_reg <= capture_compare_next;
      buffer_reg <= buffer_next;
      event_enable_reg <= event_enable_next;
      cmp_pin_reg <= cmp_pin_next;
      rdata_reg <= rdata_next;
    end
  end

  ptu_flags u_flags (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .set_in(evt_set),
    .rd_in(flag_rd),
    .wr_in(flag_wr),
    .wdata_in(wdata_reg[EVT_W-1:0]),
    .flag_out(flags_out)
  );

  // =============================================================
  // outputs
  assign cpu_ack_out = in_t2;
  assign cpu_rdata_out = rdata_reg;
  assign count_out = cycle_counter_reg;
  assign irq_out = |(flags_out & event_enable_reg);
  assign cmp_pin_out = cmp_pin_reg;
  // software must keep this off while the shared pin carries an external clock
  assign cmp_pin_oe_out = cmp_out_en_in;

  // =============================================================
  // assertions
  sequence s_taken;
    bus_reg == BUS_IDLE && cpu_req_in && run_in;
  endsequence
  sequence s_two_states;
    ##1 bus_reg == BUS_T1 ##1 (bus_reg == BUS_T2 && cpu_ack_out);
  endsequence

  property p_two_state_access;
    @(posedge clk_sys_in) disable iff (rst_in) s_taken |-> s_two_states;
  endproperty
  a_two_state_access: assert property (p_two_state_access) else $error("access not two states");

  property p_match_clear;
    @(posedge clk_sys_in) disable iff (rst_in) (cmp_match && clr_on_match_in) |=> cycle_counter_reg == CNT_RESET;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear counter");

  property p_clear_beats_write;
    @(posedge clk_sys_in) disable iff (rst_in) (clr && cnt_wr && wdata_reg != CNT_RESET) |=> cycle_counter_reg == CNT_RESET;
  endproperty
  a_clear_beats_write: assert property (p_clear_beats_write) else $error("write beat clear");

  property p_write_beats_tick;
    @(posedge clk_sys_in) disable iff (rst_in) (cnt_wr && tick && !clr) |=> cycle_counter_reg == $past(wdata_reg);
  endproperty
  a_write_beats_tick: assert property (p_write_beats_tick) else $error("tick beat write");

  property p_write_masks_match;
    @(posedge clk_sys_in) disable iff (rst_in) (in_t2 && wr_reg && addr_reg == SEL_CAPCMP) |=> $stable(cmp_pin_reg);
  endproperty
  a_write_masks_match: assert property (p_write_masks_match) else $error("match during write");

  property p_buffer_prewrite;
    @(posedge clk_sys_in) disable iff (rst_in) (buffered_in && cmp_match && !cap_evt)
      |=> capture_compare_reg == $past(buffer_reg);
  endproperty
  a_buffer_prewrite: assert property (p_buffer_prewrite) else $error("buffer transfer wrong value");

  property p_read_capture;
    @(posedge clk_sys_in) disable iff (rst_in) (in_t1 && !wr_reg && addr_reg == SEL_CAPCMP && cap_evt)
      |=> cpu_ack_out && cpu_rdata_out == $past(cycle_counter_reg);
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read missed capture");

  property p_capture_beats_write;
    @(posedge clk_sys_in) disable iff (rst_in) (cap_evt && cc_wr) |=> capture_compare_reg == $past(cycle_counter_reg);
  endproperty
  a_capture_beats_write: assert property (p_capture_beats_write) else $error("write beat capture");

  property p_capture_beats_buffer;
    @(posedge clk_sys_in) disable iff (rst_in) (cap_evt && buffered_in && buf_wr)
      |=> buffer_reg == $past(capture_compare_reg);
  endproperty
  a_capture_beats_buffer: assert property (p_capture_beats_buffer) else $error("buffer write beat capture");

  property p_clear_no_ovf;
    @(posedge clk_sys_in) disable iff (rst_in) (ovf && clr && !flags_out[EVT_OVF]) |=> !flags_out[EVT_OVF];
  endproperty
  a_clear_no_ovf: assert property (p_clear_no_ovf) else $error("overflow flag set on clear");

  property p_write_no_ovf;
    @(posedge clk_sys_in) disable iff (rst_in) (ovf && cnt_wr && !clr && !flags_out[EVT_OVF])
      |=> !flags_out[EVT_OVF] && cycle_counter_reg == $past(wdata_reg);
  endproperty
  a_write_no_ovf: assert property (p_write_no_ovf) else $error("overflow flag set on write");

  property p_stopped;
    @(posedge clk_sys_in) disable iff (rst_in) (!run_in && bus_reg == BUS_IDLE) |=> $stable(cycle_counter_reg);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_irq;
    @(posedge clk_sys_in) disable iff (rst_in) irq_out == |(flags_out & event_enable_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");

  property p_one_match;
    @(posedge clk_sys_in) disable iff (rst_in) $changed(cmp_pin_reg)
      |-> $past(tick) && $past(cycle_counter_reg) == $past(capture_compare_reg);
  endproperty
  a_one_match: assert property (p_one_match) else $error("match without input clock");
endmodule : ptu_core

// file: testbench/ptu_cpu_model.sv
// cpu partner model: two-state register accesses on the unit's access port
`timescale 1ns/10ps
module ptu_cpu_model
  import ptu_pkg::*;
(
  // clock
  input wire logic clk_sys_in,
  // answer from the unit
  input wire logic cpu_ack_in,
  input wire logic [CNT_W-1:0] cpu_rdata_in,
  // request to the unit
  output logic cpu_req_out,
  output logic cpu_wr_out,
  output logic [ADDR_W-1:0] cpu_addr_out,
  output logic [CNT_W-1:0] cpu_wdata_out
);
  initial begin
    cpu_req_out = 1'b0;
    cpu_wr_out = 1'b0;
    cpu_addr_out = '0;
    cpu_wdata_out = '0;
  end
  // =========================================
  // access: held until ack or for at most 8 cycles, then released
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d,
                        output logic [CNT_W-1:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(posedge clk_sys_in);
    cpu_req_out <= 1'b1;
    cpu_wr_out <= w;
    cpu_addr_out <= a;
    cpu_wdata_out <= d;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_sys_in);
      if (cpu_ack_in === 1'b1) begin
        ok = 1'b1;
        rd = cpu_rdata_in;
      end
    end
    // released lines carry junk so a stale value is never trusted
    cpu_req_out <= 1'b0;
    cpu_addr_out <= ~a;
    cpu_wdata_out <= ~d;
  endtask : access
  // read the flags, then write zero to the bits to clear
  task automatic clear_flags(input logic [EVT_W-1:0] bits, output logic [CNT_W-1:0] seen);
    logic ok;
    logic [CNT_W-1:0] junk;
    access(1'b0, SEL_FLAGS, '0, seen, ok);
    access(1'b1, SEL_FLAGS, seen & ~{13'h0, bits}, junk, ok);
  endtask : clear_flags
endmodule : ptu_cpu_model

// file: testbench/ptu_core_tb.sv
// self-checking bench for one timer channel with its cpu partner
`timescale 1ns/10ps
module ptu_core_tb
  import ptu_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic ext_sel = 1'b1;
  logic [1:0] pre_sel = 2'h0;
  logic cap_mode = 1'b0;
  logic buffered = 1'b0;
  logic clr_match = 1'b0;
  logic cmp_en = 1'b0;
  logic ext_a = 1'b0;
  logic capture = 1'b0;
  logic phase = 1'b0;
  logic ext_b = 1'b0;
  logic clr_cap = 1'b0;
  logic req, wr, ack, irq, pin, pin_oe;
  logic [ADDR_W-1:0] addr;
  logic [CNT_W-1:0] wdata, rdata, count, rd;
  logic [EVT_W-1:0] flags;
  int n_mismatch = 0;
  int n_tests = 0;

  ptu_core i_dut (.clk_sys_in(clk_sys), .rst_in(rst), .run_in(run), .ext_sel_in(ext_sel),
    .phase_mode_in(phase), .pre_sel_in(pre_sel), .edge_sel_in(EDGE_RISE), .capture_mode_in(cap_mode),
    .buffered_in(buffered), .clr_on_match_in(clr_match), .clr_on_capture_in(clr_cap),
    .cmp_out_en_in(cmp_en), .ext_clock_a_in(ext_a), .ext_clock_b_in(ext_b), .capture_in(capture),
    .cpu_req_in(req), .cpu_wr_in(wr), .cpu_addr_in(addr), .cpu_wdata_in(wdata), .cpu_ack_out(ack),
    .cpu_rdata_out(rdata), .count_out(count), .flags_out(flags), .irq_out(irq),
    .cmp_pin_out(pin), .cmp_pin_oe_out(pin_oe));
  ptu_cpu_model i_cpu (.clk_sys_in(clk_sys), .cpu_ack_in(ack), .cpu_rdata_in(rdata),
    .cpu_req_out(req), .cpu_wr_out(wr), .cpu_addr_out(addr), .cpu_wdata_out(wdata));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // =========================================
  // helpers
  task automatic chk(input string what, input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d, input int cap_at);
    logic ok;
    fork
      i_cpu.access(w, a, d, rd, ok);
      if (cap_at > 0) begin
        repeat (cap_at) @(posedge clk_sys);
        capture <= 1'b1;
        @(posedge clk_sys);
        capture <= 1'b0;
      end else if (cap_at < 0) begin
        // negative: rising external clock edge after that many edges
        repeat (-cap_at) @(posedge clk_sys);
        ext_a <= 1'b1;
      end
    join
    chk("ack", 16'h1, {15'h0, ok});
  endtask : acc
  // each level held far beyond 2.5 states
  task automatic ext_edge(input logic lvl, input logic lvl_b = 1'b0);
    @(posedge clk_sys);
    ext_a <= lvl;
    ext_b <= lvl_b;
    repeat (6) @(posedge clk_sys);
  endtask : ext_edge
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // =========================================
  // scenarios
  task automatic t_stop_reset();
    logic ok;
    logic [CNT_W-1:0] exp [6] = '{16'h0000, 16'hffff, 16'hffff, 16'h0000, 16'h0000, 16'h0000};
    i_cpu.access(1'b0, SEL_COUNTER, '0, rd, ok);
    chk("stopped ack", 16'h0, {15'h0, ok});
    @(posedge clk_sys);
    run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, i[ADDR_W-1:0], '0, 0);
      chk("reset value", exp[i], rd);
    end
    $display("test stop_reset done");
  endtask : t_stop_reset
  task automatic t_write_count();
    @(posedge clk_sys);
    ext_sel <= 1'b0;
    acc(1'b1, SEL_COUNTER, 16'h1000, 0);
    @(negedge clk_sys);
    chk("count after write", 16'h1000, count);
    @(negedge clk_sys);
    chk("count next", 16'h1001, count);
    $display("test write_count done");
  endtask : t_write_count
  task automatic t_period();
    int n;
    @(posedge clk_sys);
    clr_match <= 1'b1;
    cmp_en <= 1'b1;
    acc(1'b1, SEL_ENABLE, 16'h0001, 0);
    acc(1'b1, SEL_CAPCMP, 16'h0004, 0);
    acc(1'b1, SEL_COUNTER, 16'h0000, 0);
    for (n = 0; n < 20 && count !== 16'h0; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    for (n = 1; n < 20 && count !== 16'h0; n++) @(negedge clk_sys);
    chk("period", 16'h5, n[15:0]);
    chk("irq", 16'h1, {15'h0, irq});
    chk("pin oe", 16'h1, {15'h0, pin_oe});
    chk("pin toggled once", 16'h1, {15'h0, pin});
    $display("test period done");
  endtask : t_period
  task automatic t_flag_clear();
    logic [CNT_W-1:0] seen;
    @(posedge clk_sys);
    ext_sel <= 1'b1;
    cmp_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    acc(1'b1, SEL_FLAGS, 16'h0000, 0);
    @(negedge clk_sys);
    chk("unread flag", 16'h1, {15'h0, flags[EVT_MATCH]});
    i_cpu.clear_flags(3'h1, seen);
    chk("flag seen", 16'h1, {15'h0, seen[EVT_MATCH]});
    @(negedge clk_sys);
    chk("flag cleared", 16'h0, {13'h0, flags});
    chk("irq off", 16'h0, {15'h0, irq});
    $display("test flag_clear done");
  endtask : t_flag_clear
  task automatic t_wrap();
    logic [CNT_W-1:0] seen;
    acc(1'b1, SEL_CAPCMP, 16'hffff, 0);
    acc(1'b1, SEL_COUNTER, 16'hffff, 0);
    ext_edge(1'b1);
    ext_edge(1'b0);
    chk("clear on wrap", 16'h0, count);
    chk("no wrap flag", 16'h1, {13'h0, flags});
    @(posedge clk_sys);
    clr_match <= 1'b0;
    i_cpu.clear_flags(3'h1, seen);
    acc(1'b1, SEL_COUNTER, 16'hfffe, 0);
    repeat (2) begin
      ext_edge(1'b1);
      ext_edge(1'b0);
    end
    chk("overflow", 16'h3, {13'h0, flags});
    chk("wrapped", 16'h0, count);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_capture();
    @(posedge clk_sys);
    cap_mode <= 1'b1;
    acc(1'b1, SEL_COUNTER, 16'h0123, 0);
    acc(1'b1, SEL_CAPCMP, 16'habcd, 3);
    acc(1'b0, SEL_CAPCMP, '0, 0);
    chk("capture over write", 16'h0123, rd);
    acc(1'b1, SEL_COUNTER, 16'h0456, 0);
    acc(1'b0, SEL_CAPCMP, '0, 2);
    chk("capture in read", 16'h0456, rd);
    @(posedge clk_sys);
    buffered <= 1'b1;
    acc(1'b1, SEL_COUNTER, 16'h0789, 0);
    acc(1'b1, SEL_BUFFER, 16'h5555, 3);
    acc(1'b0, SEL_BUFFER, '0, 0);
    chk("buffer transfer", 16'h0456, rd);
    acc(1'b0, SEL_CAPCMP, '0, 0);
    chk("capcmp capture", 16'h0789, rd);
    $display("test capture done");
  endtask : t_capture
  task automatic t_phase();
    @(posedge clk_sys);
    cap_mode <= 1'b0;
    buffered <= 1'b0;
    phase <= 1'b1;
    acc(1'b1, SEL_COUNTER, 16'h0010, 0);
    for (int i = 0; i < 4; i++) ext_edge(!i[1], i[0] ^ i[1]);
    chk("phase up", 16'h0014, count);
    for (int i = 0; i < 4; i++) ext_edge(i[0] ^ i[1], !i[1]);
    chk("phase down", 16'h0010, count);
    $display("test phase done");
  endtask : t_phase
  task automatic t_conflict();
    logic [CNT_W-1:0] seen;
    logic was;
    @(posedge clk_sys);
    phase <= 1'b0;
    acc(1'b1, SEL_COUNTER, 16'h0030, 0);
    acc(1'b1, SEL_CAPCMP, 16'h0030, 0);
    i_cpu.clear_flags(3'h7, seen);
    was = pin;
    acc(1'b1, SEL_CAPCMP, 16'h0030, -3);
    @(negedge clk_sys);
    chk("match masked", 16'h0, {13'h0, flags});
    chk("pin held", {15'h0, was}, {15'h0, pin});
    chk("count on", 16'h0031, count);
    @(posedge clk_sys);
    buffered <= 1'b1;
    ext_edge(1'b0);
    acc(1'b1, SEL_BUFFER, 16'h0040, 0);
    acc(1'b1, SEL_COUNTER, 16'h0030, 0);
    acc(1'b1, SEL_BUFFER, 16'h0050, -3);
    acc(1'b0, SEL_CAPCMP, '0, 0);
    chk("pre-write transfer", 16'h0040, rd);
    ext_edge(1'b0);
    acc(1'b1, SEL_COUNTER, 16'hffff, 0);
    acc(1'b1, SEL_COUNTER, 16'h0100, -3);
    @(negedge clk_sys);
    chk("write over wrap", 16'h0100, count);
    chk("ovf after write", 16'h0, {15'h0, flags[EVT_OVF]});
    @(posedge clk_sys);
    cap_mode <= 1'b1;
    clr_cap <= 1'b1;
    acc(1'b1, SEL_COUNTER, 16'h0200, 3);
    @(negedge clk_sys);
    chk("clear over write", 16'h0, count);
    $display("test conflict done");
  endtask : t_conflict
  // =========================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_stop_reset();
    t_write_count();
    t_period();
    t_flag_clear();
    t_wrap();
    t_capture();
    t_phase();
    t_conflict();
    wrap_up();
  end
  initial begin
    // a few hundred cycles expected; far longer means a hang
    #200us;
    n_mismatch++;
    wrap_up();
  end
endmodule : ptu_core_tb
